//--- hdl/sfx_exc_unit.sv
// Operation
// - Packed integer operations never raise numeric exceptions.
// - Detect exactly six floating-point exception classes.
// - Report exceptions precisely when the instruction completes.
// - One flag and one mask per class.
// - Masks writable, flags and masks readable by software.
// - Unmasked exception with OS support raises SIMD trap.
// - Without OS support raise invalid-opcode trap instead.
// - Invalid flag bit 0, invalid mask bit 7.
// - Masked invalid result overwrites destination or flags.
// - Arithmetic with signaling NaN returns it quieted.
// - Square root of signaling NaN returns it quieted.
// - Precision conversion of signaling NaN returns it quieted.
// - Square root of negative non-zero returns indefinite.
// - Maximum or minimum with NaN returns second source.
// - NaN mask compares return zeros, some predicates ones.
// - Ordered flag compare with NaN sets not-comparable.
// - Infinity clashes and zero over zero return indefinite.
// - Bad float-to-integer conversion returns integer indefinite.
// - Unmasked invalid leaves every operand unchanged.
// - Quiet NaN raises invalid only for listed compares and integer conversion.
// - DAZ and FTZ never change invalid detection.
// - Truncating x87 integer store never raises SIMD exceptions.
// - Denormal flag bit 1, mask bit 8.
// - Divide-by-zero flag bit 2, mask bit 9.
// - Overflow flag bit 3, mask bit 10.
// - Status flag is OR of per-lane indications.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sfx_exc_unit #(
    parameter int NLANE = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Instruction from the floating-point datapath.
    input wire logic issue_valid_i,
    input wire sfx_pkg::sfx_op_t op_i,
    input wire logic dbl_i,
    input wire logic [2:0] pred_i,
    input wire logic [NLANE*64-1:0] src_a_i,
    input wire logic [NLANE*64-1:0] src_b_i,
    // Per-lane denormal, zero-divide, overflow, underflow, inexact.
    input wire logic [NLANE*5-1:0] dp_lane_exc_i,
    // Completion report.
    output logic done_o,
    output logic commit_o,
    output logic simd_fp_trap_o,
    output logic invalid_opcode_trap_o,
    output logic [NLANE-1:0] res_use_o,
    output logic [NLANE*64-1:0] res_o,
    output logic arith_flags_wr_o,
    output logic [2:0] arith_flags_o
);

    // Control/status word: flags, masks, DAZ, rounding, FTZ.
    logic [31:0] simd_fp_ctrl_status;
    // System control word; only the OS support bit is stored.
    logic [31:0] system_control_reg;
    // Outcome of the last completed instruction.
    logic [31:0] last_event;
    // Bus acknowledge and registered read data.
    logic ack_q;
    logic [31:0] rd_q;

    // Lane outputs.
    logic [NLANE-1:0] lane_inv;
    logic [NLANE-1:0] lane_fix;
    logic [NLANE-1:0] lane_unord;
    logic [NLANE*64-1:0] lane_res;

    // One checker per lane.
    genvar gl;
    generate
        for (gl = 0; gl < NLANE; gl++) begin : g_lane
            sfx_lane_chk #(
                .LANE_IDX(gl)
            ) u_lane (
                .op_i(op_i),
                .dbl_i(dbl_i),
                .pred_i(pred_i),
                .a_i(src_a_i[gl*64 +: 64]),
                .b_i(src_b_i[gl*64 +: 64]),
                .inv_o(lane_inv[gl]),
                .fix_o(lane_fix[gl]),
                .unord_o(lane_unord[gl]),
                .res_o(lane_res[gl*64 +: 64])
            );
        end
    endgenerate

    // OR of the datapath's lane indications for the other five classes.
    logic [4:0] dp_any;
    always_comb begin
        dp_any = 5'h0;
        for (int i = 0; i < NLANE; i++) begin
            dp_any = dp_any | dp_lane_exc_i[i*5 +: 5];
        end
    end

    // Integer and x87 store groups cannot raise anything here.
    wire no_fp_exc = (op_i == sfx_pkg::OP_PINT)
                   | (op_i == sfx_pkg::OP_TRUNC_STORE);
    // Six classes: invalid in bit 0, then denormal, zero-divide, etc.
    wire [5:0] exc_vec = no_fp_exc ? 6'h0
        : {dp_any, |lane_inv};
    wire [5:0] exc_set = issue_valid_i ? exc_vec : 6'h0;
    wire [5:0] masks = simd_fp_ctrl_status[sfx_pkg::MSK_BASE +: sfx_pkg::NEXC];
    wire [5:0] unmasked = exc_vec & ~masks;
    wire trap_any = |unmasked;
    wire os_support = system_control_reg[sfx_pkg::OS_TRAP_BIT];

    // Bus decode. Writes land on the edge at which the master sees ack.
    wire bus_req = cyc_i & stb_i;
    wire wr_fire = bus_req & we_i & ack_q;
    wire hit_cs = adr_i == sfx_pkg::ADR_CTRL_STATUS;
    wire hit_sys = adr_i == sfx_pkg::ADR_SYS_CTRL;
    wire hit_ev = adr_i == sfx_pkg::ADR_LAST_EVENT;
    wire [31:0] byte_en = {{8{sel_i[3]}}, {8{sel_i[2]}},
                           {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] cs_wm = byte_en & sfx_pkg::CTRL_STATUS_WMASK;
    wire [31:0] sys_wm = byte_en & sfx_pkg::SYS_CTRL_WMASK;
    // Unmapped addresses read as zero; writes to them are dropped.
    wire [31:0] rd_mux = hit_cs ? simd_fp_ctrl_status
                       : hit_sys ? system_control_reg
                       : hit_ev ? last_event : 32'h0;

    // Software write first, hardware flag set over it, so a set in the
    // same cycle as a clear is kept.
    wire [31:0] cs_after_wr = (wr_fire & hit_cs)
        ? ((simd_fp_ctrl_status & ~cs_wm) | (dat_i & cs_wm))
        : simd_fp_ctrl_status;
    wire [31:0] next_ctrl_status = cs_after_wr
                                 | {26'h0, exc_set};
    wire [31:0] next_sys_ctrl = (wr_fire & hit_sys)
        ? ((system_control_reg & ~sys_wm) | (dat_i & sys_wm))
        : system_control_reg;

    // Bus handshake: ack one cycle after the request, then low once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rd_q <= 32'h0;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req & ~ack_q) begin
                rd_q <= rd_mux;
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rd_q;

    // Architectural registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            simd_fp_ctrl_status <= sfx_pkg::CTRL_STATUS_RST;
            system_control_reg <= sfx_pkg::SYS_CTRL_RST;
        end else begin
            simd_fp_ctrl_status <= next_ctrl_status;
            system_control_reg <= next_sys_ctrl;
        end
    end

    // Completion stage: one cycle after issue the verdict is out, and
    // nothing later has been committed because commit waits for it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
            commit_o <= 1'b0;
            simd_fp_trap_o <= 1'b0;
            invalid_opcode_trap_o <= 1'b0;
            res_use_o <= '0;
            res_o <= '0;
            arith_flags_wr_o <= 1'b0;
            arith_flags_o <= 3'h0;
            last_event <= 32'h0;
        end else begin
            done_o <= issue_valid_i;
            commit_o <= issue_valid_i & ~trap_any;
            simd_fp_trap_o <= issue_valid_i & trap_any
                            & os_support;
            invalid_opcode_trap_o <= issue_valid_i & trap_any
                                   & ~os_support;
            // A trap leaves the destination alone.
            res_use_o <= (issue_valid_i & ~trap_any)
                       ? lane_fix : '0;
            res_o <= lane_res;
            arith_flags_wr_o <= issue_valid_i & ~trap_any
                              & (op_i == sfx_pkg::OP_COMI)
                              & lane_unord[0];
            arith_flags_o <= sfx_pkg::NOT_COMPARABLE;
            if (issue_valid_i) begin
                last_event <= {22'h0, trap_any & ~os_support,
                               trap_any & os_support, 2'h0, exc_vec};
            end
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_int_quiet;
        issue_valid_i && op_i == sfx_pkg::OP_PINT
            |=> !simd_fp_trap_o && !invalid_opcode_trap_o && commit_o;
    endproperty
    a_int_quiet: assert property (p_int_quiet)
        else $error("packed integer op raised a trap");

    property p_trunc_quiet;
        issue_valid_i && op_i == sfx_pkg::OP_TRUNC_STORE
            |=> commit_o && res_use_o == '0;
    endproperty
    a_trunc_quiet: assert property (p_trunc_quiet)
        else $error("truncating store raised a SIMD exception");

    property p_done_next;
        issue_valid_i |=> done_o ##1 (done_o == $past(issue_valid_i));
    endproperty
    a_done_next: assert property (p_done_next)
        else $error("completion not reported one cycle after issue");

    property p_simd_trap;
        issue_valid_i && trap_any && os_support
            |=> simd_fp_trap_o && !invalid_opcode_trap_o && !commit_o;
    endproperty
    a_simd_trap: assert property (p_simd_trap)
        else $error("unmasked exception did not raise SIMD trap");

    property p_ud_trap;
        issue_valid_i && trap_any && !os_support
            |=> invalid_opcode_trap_o && !simd_fp_trap_o;
    endproperty
    a_ud_trap: assert property (p_ud_trap)
        else $error("missing invalid-opcode trap without OS support");

    property p_inv_flag;
        issue_valid_i && !no_fp_exc && |lane_inv
            |=> simd_fp_ctrl_status[sfx_pkg::FLG_INVALID];
    endproperty
    a_inv_flag: assert property (p_inv_flag)
        else $error("invalid flag not set by a lane");

    property p_sticky;
        simd_fp_ctrl_status[5:0] != 6'h0 && !(wr_fire && hit_cs)
            |=> (simd_fp_ctrl_status[5:0] & $past(simd_fp_ctrl_status[5:0]))
                == $past(simd_fp_ctrl_status[5:0]);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared without a software write");

    property p_masked_no_trap;
        issue_valid_i && (exc_vec & ~masks) == 6'h0
            |=> !simd_fp_trap_o && !invalid_opcode_trap_o && commit_o;
    endproperty
    a_masked_no_trap: assert property (p_masked_no_trap)
        else $error("masked exception caused a trap");

    property p_trap_keeps_dest;
        done_o && !commit_o |-> res_use_o == '0 && !arith_flags_wr_o;
    endproperty
    a_trap_keeps_dest: assert property (p_trap_keeps_dest)
        else $error("trapping instruction changed its destination");

    property p_comi_flags;
        issue_valid_i && op_i == sfx_pkg::OP_COMI && lane_unord[0]
            && !trap_any
            |=> arith_flags_wr_o
                && arith_flags_o == sfx_pkg::NOT_COMPARABLE;
    endproperty
    a_comi_flags: assert property (p_comi_flags)
        else $error("unordered compare did not write not-comparable");

    property p_ack_pulse;
        bus_req && !ack_q |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack not a single cycle pulse");

    c_simd_trap: cover property (issue_valid_i ##1 simd_fp_trap_o);
    c_ud_trap: cover property (issue_valid_i ##1 invalid_opcode_trap_o);
    c_masked_fix: cover property (issue_valid_i ##1 (commit_o && |res_use_o));
    c_flag_clear: cover property (wr_fire && hit_cs
                                  && simd_fp_ctrl_status[0]);

endmodule // sfx_exc_unit
`default_nettype wire

//--- pkg/sfx_pkg.sv
package sfx_pkg;

    // Register byte addresses on the bus.
    localparam logic [7:0] ADR_CTRL_STATUS = 8'h00;
    localparam logic [7:0] ADR_SYS_CTRL = 8'h04;
    localparam logic [7:0] ADR_LAST_EVENT = 8'h08;

    // Exception classes and their flag positions in the control/status word.
    localparam int NEXC = 6;
    localparam int FLG_INVALID = 0;
    localparam int FLG_DENORM = 1;
    localparam int FLG_DIV_ZERO = 2;
    localparam int FLG_OVERFLOW = 3;
    localparam int FLG_UNDERFLOW = 4;
    localparam int FLG_INEXACT = 5;
    // Masks sit seven bits above the flags (invalid mask at bit 7).
    localparam int MSK_BASE = 7;
    localparam int DAZ_BIT = 6;
    localparam int FTZ_BIT = 15;
    localparam int OS_TRAP_BIT = 10;
    localparam int ST_SIMD_TRAP_BIT = 8;
    localparam int ST_UD_TRAP_BIT = 9;

    // Values after reset and writable bits.
    localparam logic [31:0] CTRL_STATUS_RST = 32'h0000_1F80;
    localparam logic [31:0] CTRL_STATUS_WMASK = 32'h0000_FFFF;
    localparam logic [31:0] SYS_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SYS_CTRL_WMASK = 32'h0000_0400;

    // Special encodings.
    localparam logic [31:0] QNAN_IND_S = 32'hFFC0_0000;
    localparam logic [63:0] QNAN_IND_D = 64'hFFF8_0000_0000_0000;
    localparam logic [31:0] QBIT_S = 32'h0040_0000;
    localparam logic [63:0] QBIT_D = 64'h0008_0000_0000_0000;
    localparam logic [31:0] INT_INDEF = 32'h8000_0000;
    localparam logic [10:0] INT_EXP_LIM_D = 11'h41E;
    localparam logic [10:0] INT_EXP_LIM_S = 11'h09E;
    // Zero, parity and carry flags all set: unordered.
    localparam logic [2:0] NOT_COMPARABLE = 3'h7;

    // Compare predicates.
    localparam logic [2:0] PRED_EQ = 3'h0;
    localparam logic [2:0] PRED_LT = 3'h1;
    localparam logic [2:0] PRED_LE = 3'h2;
    localparam logic [2:0] PRED_UNORD = 3'h3;
    localparam logic [2:0] PRED_NEQ = 3'h4;
    localparam logic [2:0] PRED_NLT = 3'h5;
    localparam logic [2:0] PRED_NLE = 3'h6;
    localparam logic [2:0] PRED_ORD = 3'h7;

    // Instruction groups as seen by the checker.
    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_ADDSUB, OP_HADD, OP_HSUB,
        OP_SQRT, OP_MAX, OP_MIN, OP_CMP, OP_COMI, OP_CVT_FP, OP_CVT_INT,
        OP_PINT, OP_TRUNC_STORE
    } sfx_op_t;

endpackage

//--- hdl/sfx_lane_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Invalid-operation check and masked result for one 64-bit lane.
// Single precision lives in the low 32 bits of the lane.
module sfx_lane_chk #(
    parameter int LANE_IDX = 0
) (
    input wire sfx_pkg::sfx_op_t op_i,
    input wire logic dbl_i,
    input wire logic [2:0] pred_i,
    input wire logic [63:0] a_i,
    input wire logic [63:0] b_i,
    output logic inv_o,
    output logic fix_o,
    output logic unord_o,
    output logic [63:0] res_o
);

    // Class bits {snan, qnan, inf, zero, neg} from raw operand bits.
    function automatic logic [4:0] cls(input logic [63:0] v, input logic d);
        logic eall;
        logic ezero;
        logic mz;
        logic qb;
        eall = d ? &v[62:52] : &v[30:23];
        ezero = d ? ~|v[62:52] : ~|v[30:23];
        mz = d ? ~|v[51:0] : ~|v[22:0];
        qb = d ? v[51] : v[22];
        cls = {eall & ~mz & ~qb, eall & ~mz & qb, eall & mz, ezero & mz,
               d ? v[63] : v[31]};
    endfunction

    // Signaling NaN turned quiet in its own format.
    function automatic logic [63:0] quiet(input logic [63:0] v,
                                          input logic d);
        quiet = d ? (v | sfx_pkg::QBIT_D) : {32'h0, v[31:0] | sfx_pkg::QBIT_S};
    endfunction

    // Raw bits are classified, so DAZ and FTZ never change detection.
    wire [4:0] ca = cls(a_i, dbl_i);
    wire [4:0] cb = cls(b_i, dbl_i);
    wire snan_a = ca[4];
    wire snan_b = cb[4];
    wire nan_a = ca[4] | ca[3];
    wire nan_b = cb[4] | cb[3];
    wire inf_a = ca[2];
    wire inf_b = cb[2];
    wire zero_a = ca[1];
    wire zero_b = cb[1];
    wire neg_a = ca[0];
    wire neg_b = cb[0];
    wire any_snan = snan_a | snan_b;
    wire any_nan = nan_a | nan_b;
    wire [63:0] snan_src = quiet(snan_a ? a_i : b_i, dbl_i);
    wire [63:0] indef = dbl_i ? sfx_pkg::QNAN_IND_D
                              : {32'h0, sfx_pkg::QNAN_IND_S};
    wire [63:0] all_ones = dbl_i ? 64'hFFFF_FFFF_FFFF_FFFF
                                 : 64'h0000_0000_FFFF_FFFF;
    // Alternating add/subtract subtracts in even lanes.
    wire eff_sub = (op_i == sfx_pkg::OP_SUB) | (op_i == sfx_pkg::OP_HSUB)
                 | ((op_i == sfx_pkg::OP_ADDSUB) & (LANE_IDX % 2 == 0));
    wire inf_clash = inf_a & inf_b & (neg_a ^ neg_b ^ eff_sub);
    // Integer conversion range test on the exponent field.
    wire [10:0] exp_a = dbl_i ? a_i[62:52] : {3'h0, a_i[30:23]};
    wire [10:0] exp_lim = dbl_i ? sfx_pkg::INT_EXP_LIM_D
                                : sfx_pkg::INT_EXP_LIM_S;
    wire mz_a = dbl_i ? ~|a_i[51:0] : ~|a_i[22:0];
    wire out_range = (exp_a > exp_lim) | ((exp_a == exp_lim) & ~(neg_a & mz_a));
    // Quiet NaNs trap only for ordered compares, the relational masks and integer conversion.
    wire qnan_traps = (pred_i == sfx_pkg::PRED_LT) | (pred_i == sfx_pkg::PRED_LE)
                    | (pred_i == sfx_pkg::PRED_NLT)
                    | (pred_i == sfx_pkg::PRED_NLE);
    wire cmp_ones = (pred_i == sfx_pkg::PRED_NEQ)
                  | (pred_i == sfx_pkg::PRED_UNORD)
                  | (pred_i == sfx_pkg::PRED_NLT)
                  | (pred_i == sfx_pkg::PRED_NLE);

    assign unord_o = any_nan;

    // Per-group detection and the value that replaces the result.
    always_comb begin
        inv_o = 1'b0;
        fix_o = 1'b0;
        res_o = 64'h0;
        case (op_i)
            sfx_pkg::OP_ADD, sfx_pkg::OP_SUB, sfx_pkg::OP_ADDSUB,
            sfx_pkg::OP_HADD, sfx_pkg::OP_HSUB: begin
                inv_o = any_snan | inf_clash;
                res_o = any_snan ? snan_src : indef;
                fix_o = inv_o;
            end
            sfx_pkg::OP_MUL: begin
                inv_o = any_snan | (inf_a & zero_b) | (zero_a & inf_b);
                res_o = any_snan ? snan_src : indef;
                fix_o = inv_o;
            end
            sfx_pkg::OP_DIV: begin
                inv_o = any_snan | (zero_a & zero_b) | (inf_a & inf_b);
                res_o = any_snan ? snan_src : indef;
                fix_o = inv_o;
            end
            sfx_pkg::OP_SQRT: begin
                inv_o = snan_a | (neg_a & ~zero_a & ~nan_a);
                res_o = snan_a ? quiet(a_i, dbl_i) : indef;
                fix_o = inv_o;
            end
            sfx_pkg::OP_MAX, sfx_pkg::OP_MIN: begin
                // Any NaN returns the second source; only a signaling one
                // raises the flag.
                inv_o = any_snan;
                res_o = b_i;
                fix_o = any_nan;
            end
            sfx_pkg::OP_CMP: begin
                inv_o = any_snan | (any_nan & qnan_traps);
                res_o = cmp_ones ? all_ones : 64'h0;
                fix_o = any_nan;
            end
            sfx_pkg::OP_COMI: begin
                // Flags instead of a destination value.
                inv_o = any_nan;
                fix_o = 1'b0;
            end
            sfx_pkg::OP_CVT_FP: begin
                // dbl_i names the source format; result is the other one.
                inv_o = snan_a;
                res_o = dbl_i ? {32'h0, a_i[63], 8'hFF,
                                 a_i[51:29] | 23'h40_0000}
                              : {a_i[31], 11'h7FF,
                                 a_i[22:0] | 23'h40_0000, 29'h0};
                fix_o = inv_o;
            end
            sfx_pkg::OP_CVT_INT: begin
                inv_o = nan_a | inf_a | out_range;
                res_o = {32'h0, sfx_pkg::INT_INDEF};
                fix_o = inv_o;
            end
            default: begin
                // Packed integer and the x87 truncating store never flag.
                inv_o = 1'b0;
            end
        endcase
    end

endmodule // sfx_lane_chk
`default_nettype wire

//--- test/sfx_dp_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in datapath: one instruction per call, operands scrambled after.
module sfx_dp_model #(
    parameter int NLANE = 2
) (
    input wire logic clk_i,
    output logic iv_o,
    output var sfx_pkg::sfx_op_t op_o,
    output logic [NLANE*64-1:0] a_o,
    output logic [NLANE*64-1:0] b_o,
    output logic [NLANE*5-1:0] exc_o
);
    initial begin
        iv_o = 1'b0;
        op_o = sfx_pkg::OP_PINT;
        a_o = '0;
        b_o = '1;
        exc_o = '0;
    end
    // Idle operands flip each issue, so a stale value never passes.
    task automatic send(input sfx_pkg::sfx_op_t op,
        input logic [63:0] a, input logic [63:0] b,
        input logic [NLANE*5-1:0] exc);
        @(posedge clk_i);
        iv_o <= 1'b1;
        op_o <= op;
        a_o <= (NLANE*64)'(a);
        b_o <= (NLANE*64)'(b);
        exc_o <= exc;
        @(posedge clk_i);
        iv_o <= 1'b0;
        a_o <= ~a_o;
        b_o <= ~b_o;
        exc_o <= '0;
    endtask
endmodule // sfx_dp_model
`default_nettype wire

//--- test/sfx_exc_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sfx_exc_unit_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd, bq;
    logic iv, ack, done, cm, xm, ud, afw;
    logic [2:0] af;
    sfx_pkg::sfx_op_t op;
    logic [127:0] sa, sb, res;
    logic [9:0] lx;
    logic [1:0] ru;
    int error_cnt = 0;
    int check_count = 0;
    int ncyc = 0;
    // Operand format and compare predicate, changed only at a clock edge.
    logic dbl = 1'b0;
    logic [2:0] pred = 3'h0;
    sfx_dp_model i_dp (.clk_i(clk_i), .iv_o(iv), .op_o(op), .a_o(sa),
        .b_o(sb), .exc_o(lx));
    sfx_exc_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd),
        .dat_o(rd), .ack_o(ack), .issue_valid_i(iv), .op_i(op),
        .dbl_i(dbl), .pred_i(pred), .src_a_i(sa), .src_b_i(sb),
        .dp_lane_exc_i(lx), .done_o(done), .commit_o(cm),
        .simd_fp_trap_o(xm), .invalid_opcode_trap_o(ud), .res_use_o(ru),
        .res_o(res), .arith_flags_wr_o(afw), .arith_flags_o(af));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // Classic cycle; waits for ack as long as the timeout allows.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        bq = rd;
        cyc <= 1'b0;
    endtask
    task automatic iss(input sfx_pkg::sfx_op_t o, input logic [63:0] a,
        input logic [63:0] b, input logic [9:0] x);
        i_dp.send(o, a, b, x);
        #1;
        chk(done, 1'b1);
    endtask
    // Lane 0 carries the case; lane 1 holds zeros and must stay unfixed.
    task automatic t_masked();
        sfx_pkg::sfx_op_t o[5] = '{sfx_pkg::OP_ADD, sfx_pkg::OP_SQRT,
            sfx_pkg::OP_SUB, sfx_pkg::OP_CVT_INT, sfx_pkg::OP_MAX};
        logic [31:0] a[5] = '{32'h7F800001, 32'hBF800000, 32'h7F800000,
            32'h7FC00000, 32'h7FC00000};
        logic [31:0] b[5] = '{32'h3F800000, 32'h3F800000, 32'h7F800000,
            32'h3F800000, 32'h3F800000};
        logic [31:0] e[5] = '{32'h7FC00001, 32'hFFC00000, 32'hFFC00000,
            32'h80000000, 32'h3F800000};
        for (int i = 0; i < 5; i++) begin
            iss(o[i], 64'(a[i]), 64'(b[i]), 10'h000);
            chk({cm, ru, res[31:0]},
                {3'h5, e[i]});
        end
        bus(1'b0, sfx_pkg::ADR_CTRL_STATUS, 32'h0);
        chk(bq, 32'h1F81);
        $display("masked results done");
    endtask
    // Mask compares and a narrowing conversion, with DAZ and FTZ set.
    task automatic t_cmp();
        logic [2:0] p[2] = '{sfx_pkg::PRED_NEQ, sfx_pkg::PRED_LT};
        logic [31:0] e[2] = '{32'hFFFFFFFF, 32'h0};
        bus(1'b1, sfx_pkg::ADR_CTRL_STATUS, 32'h9FC0);
        for (int i = 0; i < 2; i++) begin
            pred <= p[i];
            iss(sfx_pkg::OP_CMP, 64'h7FC00000, 64'h0, 10'h000);
            chk({cm, ru, res[31:0]}, {3'h5, e[i]});
            bus(1'b0, sfx_pkg::ADR_CTRL_STATUS, 32'h0);
            chk(bq, 32'h9FC0 | 32'(i));
        end
        bus(1'b1, sfx_pkg::ADR_CTRL_STATUS, 32'h9FC0);
        dbl <= 1'b1;
        iss(sfx_pkg::OP_CVT_FP, 64'h7FF4000000000000, 64'h0, 10'h000);
        chk({cm, ru, res[31:0]}, {3'h5, 32'h7FE00000});
        bus(1'b0, sfx_pkg::ADR_CTRL_STATUS, 32'h0);
        dbl <= 1'b0;
        chk(bq, 32'h9FC1);
        $display("compare tests done");
    endtask
    task automatic t_flags();
        bus(1'b1, sfx_pkg::ADR_CTRL_STATUS, 32'h1F80);
        iss(sfx_pkg::OP_COMI, 64'h7FC00000, 64'h0, 10'h000);
        chk({afw, af}, 4'hF);
        iss(sfx_pkg::OP_PINT, 64'h7F800001, 64'h0, 10'h000);
        iss(sfx_pkg::OP_TRUNC_STORE, 64'h7F800001, 64'h0, 10'h000);
        iss(sfx_pkg::OP_ADD, 64'h0, 64'h0, 10'h080);
        bus(1'b0, sfx_pkg::ADR_CTRL_STATUS, 32'h0);
        chk(bq, 32'h1F89);
        bus(1'b0, 8'h0C, 32'h0);
        chk(bq, 32'h0);
        $display("flag tests done");
    endtask
    task automatic t_trap();
        bus(1'b1, sfx_pkg::ADR_CTRL_STATUS, 32'h1F00);
        iss(sfx_pkg::OP_ADD, 64'h7F800001, 64'h0, 10'h000);
        chk({ud, xm, cm, ru}, 5'h10);
        bus(1'b1, sfx_pkg::ADR_SYS_CTRL, 32'h0400);
        iss(sfx_pkg::OP_ADD, 64'h7F800001, 64'h0, 10'h000);
        chk({ud, xm, cm, ru}, 5'h08);
        bus(1'b0, sfx_pkg::ADR_CTRL_STATUS, 32'h0);
        chk(bq, 32'h1F01);
        bus(1'b0, sfx_pkg::ADR_LAST_EVENT, 32'h0);
        chk(bq, 32'h0101);
        $display("trap tests done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and closes the run.
    always @(posedge clk_i) begin
        ncyc++;
        if (ncyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, sfx_pkg::ADR_CTRL_STATUS, 32'h0);
        chk(bq, sfx_pkg::CTRL_STATUS_RST);
        t_masked();
        t_cmp();
        t_flags();
        t_trap();
        summarize();
    end
endmodule // sfx_exc_unit_tb
`default_nettype wire
